// [dac_frame_device.sv]
/*
   DAC serial input end: a link-clock shifter that gathers 24-bit words
   and drives readback bits, and a system-clock side that holds input and
   DAC registers, applies load strobe and clear, and presents DAC values.
   Command word: bit 23 asks for readback, bits 17:16 pick the channel
   and bits 13:0 carry the DAC code. A readback answer leaves on
   serial_out during the frame that follows the read command.
   Assumes the host keeps a gap between frames so the readback word is
   settled before the next frame starts, that the link clock stands
   still outside frames, and that every frame carries whole words.
*/
`default_nettype none

module dac_frame_device (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   dac_link_if.device link,
   output logic [dac_link_pkg::CHANNELS-1:0][dac_link_pkg::DATA_BITS-1:0] dac_value,
   output logic dac_update
);

   // Link-clock domain state
   typedef struct packed {
      logic [dac_link_pkg::WORD_BITS-2:0] sr;
      logic [4:0] cnt;
      logic [dac_link_pkg::WORD_BITS-1:0] word;
      logic tgl;
      logic sout;
      logic [dac_link_pkg::WORD_BITS-1:0] rbuf;
   } link_state_t;

   // System-clock domain state
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] filt;
      logic tgl_seen;
      logic load_seen;
      logic pending;
      logic [dac_link_pkg::CHANNELS-1:0][dac_link_pkg::DATA_BITS-1:0] inp;
      logic [dac_link_pkg::CHANNELS-1:0][dac_link_pkg::DATA_BITS-1:0] dac;
      logic [dac_link_pkg::WORD_BITS-1:0] rb;
      logic upd;
   } core_state_t;

   link_state_t lk_ff;
   link_state_t nxt_lk;
   core_state_t core_ff;
   core_state_t nxt_core;

   // Channel field of a command word
   function automatic logic [dac_link_pkg::CH_BITS-1:0] word_channel(
      input logic [dac_link_pkg::WORD_BITS-1:0] w);
      word_channel = w[dac_link_pkg::CH_LSB +: dac_link_pkg::CH_BITS];
   endfunction

   // Data field of a command word
   function automatic dac_link_pkg::dac_word_t word_data(
      input logic [dac_link_pkg::WORD_BITS-1:0] w);
      word_data = w[dac_link_pkg::DATA_BITS-1:0];
   endfunction

   // Readback word: channel and DAC register, other bits zero
   function automatic logic [dac_link_pkg::WORD_BITS-1:0] readback_word(
      input logic [dac_link_pkg::CH_BITS-1:0] ch,
      input dac_link_pkg::dac_word_t value);
      readback_word = '0;
      readback_word[dac_link_pkg::CH_LSB +: dac_link_pkg::CH_BITS] = ch;
      readback_word[dac_link_pkg::DATA_BITS-1:0] = value;
   endfunction

   // Link side: shifts on the falling link clock edge
   always_comb begin
      nxt_lk = lk_ff;
      if (!link.transmit_frame_sync_n) begin
         // First fall of a frame takes the readback word, settled by the frame gap
         if (lk_ff.cnt == 5'h00) begin
            nxt_lk.rbuf = core_ff.rb;
            nxt_lk.sout = core_ff.rb[dac_link_pkg::WORD_BITS-1];
         end else begin
            nxt_lk.sout = lk_ff.rbuf[5'(dac_link_pkg::LAST_BIT - lk_ff.cnt)];
         end
         // Last bit closes the word and flips the toggle
         if (lk_ff.cnt == dac_link_pkg::LAST_BIT) begin
            nxt_lk.word = {lk_ff.sr, link.serial_in};
            nxt_lk.tgl = ~lk_ff.tgl;
            nxt_lk.cnt = '0;
         end else begin
            nxt_lk.sr = {lk_ff.sr[dac_link_pkg::WORD_BITS-3:0], link.serial_in};
            nxt_lk.cnt = 5'(lk_ff.cnt + 5'h01);
         end
      end
   end

   // Reset acts without the link clock, which stands still between frames
   always_ff @(negedge link.link_clk or posedge rst) begin
      if (rst) begin
         lk_ff <= '0;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // Events seen on the system side after synchronisation
   logic word_new;
   logic load_fall;
   logic update_due;
   wire [dac_link_pkg::CHANNELS-1:0] chan_sel;

   // Toggle differs from the last one seen: a word has landed
   assign word_new = core_ff.filt[dac_link_pkg::SY_TGL] != core_ff.tgl_seen;
   // Falling edge of the synchronised load strobe
   assign load_fall = core_ff.load_seen & ~core_ff.filt[dac_link_pkg::SY_LOAD];
   // Strobe low moves input registers across at frame end or on its falling edge
   assign update_due = core_ff.pending && !core_ff.filt[dac_link_pkg::SY_LOAD] &&
                       (core_ff.filt[dac_link_pkg::SY_FRAME] || load_fall);

   // One select line per channel for a word written from the link
   for (genvar gi = 0; gi < dac_link_pkg::CHANNELS; gi++) begin : g_chan_sel
      assign chan_sel[gi] = !lk_ff.word[dac_link_pkg::RD_BIT] &&
                            (int'(word_channel(lk_ff.word)) == gi);
   end

   // System side: synchronise pins and word toggle, then act
   always_comb begin
      logic [dac_link_pkg::CH_BITS-1:0] ch;
      ch = word_channel(lk_ff.word);
      nxt_core = core_ff;
      nxt_core.upd = 1'b0;
      if (ce) begin
         // Three stages for the pins and the word toggle
         nxt_core.s1 = {lk_ff.tgl, link.clear_outputs_n, link.load_strobe_n,
                        link.transmit_frame_sync_n};
         nxt_core.s2 = core_ff.s1;
         nxt_core.s3 = core_ff.s2;
         nxt_core.filt = dac_link_pkg::sync_filter(core_ff.s2, core_ff.s3, core_ff.filt);
         nxt_core.tgl_seen = core_ff.filt[dac_link_pkg::SY_TGL];
         nxt_core.load_seen = core_ff.filt[dac_link_pkg::SY_LOAD];

         if (update_due) begin
            nxt_core.dac = core_ff.inp;
            nxt_core.pending = 1'b0;
            nxt_core.upd = 1'b1;
         end

         // New word from the link; a write here keeps pending set
         if (word_new) begin
            if (lk_ff.word[dac_link_pkg::RD_BIT]) begin
               nxt_core.rb = readback_word(ch, core_ff.dac[ch]);
            end else begin
               nxt_core.pending = 1'b1;
            end
            for (int i = 0; i < dac_link_pkg::CHANNELS; i++) begin
               if (chan_sel[i]) begin
                  nxt_core.inp[i] = word_data(lk_ff.word);
               end
            end
         end

         // Clear holds DAC registers at zero
         if (!core_ff.filt[dac_link_pkg::SY_CLEAR]) begin
            nxt_core.dac = '0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         core_ff <= '{
            s1: dac_link_pkg::SYNC_RST,
            s2: dac_link_pkg::SYNC_RST,
            s3: dac_link_pkg::SYNC_RST,
            filt: dac_link_pkg::SYNC_RST,
            tgl_seen: 1'b0,
            // Load edge detector starts at the pin's idle level: no false edge
            load_seen: 1'b1,
            pending: 1'b0,
            inp: '0,
            dac: '0,
            rb: '0,
            upd: 1'b0
         };
      end else begin
         core_ff <= nxt_core;
      end
   end

   // Outputs come straight from registers
   assign link.serial_out = lk_ff.sout;
   assign dac_value = core_ff.dac;
   assign dac_update = core_ff.upd;

endmodule

`default_nettype wire

// [dac_link_pkg.sv]
/*
   Shared constants, types and helpers for the serial DAC frame link:
   word layout, link timing counts, synchroniser layout and host states.
   Assumes both ends run their system clock at the rate given below.
*/
`default_nettype none

package dac_link_pkg;

   // Word and channel layout
   localparam int WORD_BITS = 24;
   localparam int DATA_BITS = 14;
   localparam int CHANNELS = 4;
   localparam int CH_BITS = 2;
   localparam int RD_BIT = 23;
   localparam int CH_LSB = 16;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam logic [4:0] WORD_COUNT = 5'h18;

   // Timing, system clock 100 ns
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCLK_HALF_NS = 600;
   localparam int LOAD_PULSE_NS = 200;
   localparam int GAP_NS = 1000;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SCLK_HALF_TMR = 4'(SCLK_HALF_CYC - 1);
   localparam logic [3:0] LOAD_PULSE_TMR = 4'(LOAD_PULSE_CYC - 1);
   localparam logic [3:0] GAP_TMR = 4'(GAP_CYC - 1);

   // Device synchroniser bit positions and reset value
   localparam int SY_FRAME = 0;
   localparam int SY_LOAD = 1;
   localparam int SY_CLEAR = 2;
   localparam int SY_TGL = 3;
   localparam logic [3:0] SYNC_RST = 4'h7;

   typedef logic [DATA_BITS-1:0] dac_word_t;

   typedef enum logic [2:0] {
      H_IDLE,
      H_HIGH,
      H_LOW,
      H_LOAD,
      H_GAP
   } host_state_t;

   // New filtered value: follows the input once stages two and three agree
   function automatic logic [3:0] sync_filter(input logic [3:0] s2, input logic [3:0] s3,
                                              input logic [3:0] filt);
      sync_filter = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
   endfunction

endpackage

`default_nettype wire

// [dac_link_if.sv]
/*
   Pin bundle between the host serial master and the DAC serial input.
   Assumes the host makes the link clock; all pins are one-way.
*/
`default_nettype none

interface dac_link_if;
   logic link_clk;
   logic serial_in;
   logic transmit_frame_sync_n;
   logic load_strobe_n;
   logic clear_outputs_n;
   logic serial_out;

   modport host (
      output link_clk,
      output serial_in,
      output transmit_frame_sync_n,
      output load_strobe_n,
      output clear_outputs_n,
      input serial_out
   );

   modport device (
      input link_clk,
      input serial_in,
      input transmit_frame_sync_n,
      input load_strobe_n,
      input clear_outputs_n,
      output serial_out
   );
endinterface

`default_nettype wire

// [dac_frame_host.sv]
/*
   Host serial master for the DAC link: takes a 24-bit command, makes the
   link clock from the system clock, shifts the word MSB first, gathers
   the readback bits and drives the load strobe and clear pins.
   Assumes the command source holds its word while cmd_valid is high.
*/
`default_nettype none

module dac_frame_host (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   dac_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [dac_link_pkg::WORD_BITS-1:0] cmd_word,
   input wire logic cmd_load,
   input wire logic auto_load,
   input wire logic clear_req,
   output logic rsp_valid,
   output logic [dac_link_pkg::WORD_BITS-1:0] rsp_word
);

   typedef struct packed {
      dac_link_pkg::host_state_t state;
      logic [3:0] tmr;
      logic [4:0] cnt;
      logic [dac_link_pkg::WORD_BITS-1:0] tx;
      logic [dac_link_pkg::WORD_BITS-1:0] rx;
      logic sclk;
      logic frame_n;
      logic sin;
      logic load_n;
      logic clear_n;
      logic load_req;
      logic s1;
      logic s2;
      logic s3;
      logic filt;
      logic rsp_valid;
      logic [dac_link_pkg::WORD_BITS-1:0] rsp_word;
   } host_reg_t;

   host_reg_t h_ff;
   host_reg_t nxt_h;

   always_comb begin
      logic [3:0] f;
      f = '0;
      nxt_h = h_ff;
      nxt_h.rsp_valid = 1'b0;
      if (ce) begin
         nxt_h.s1 = link.serial_out;
         nxt_h.s2 = h_ff.s1;
         nxt_h.s3 = h_ff.s2;
         f = dac_link_pkg::sync_filter({3'h0, h_ff.s2}, {3'h0, h_ff.s3}, {3'h0, h_ff.filt});
         nxt_h.filt = f[0];
         nxt_h.clear_n = ~clear_req;
         unique case (h_ff.state)
            dac_link_pkg::H_IDLE: begin
               nxt_h.load_n = ~auto_load;
               if (cmd_valid) begin
                  nxt_h.frame_n = 1'b0;
                  nxt_h.tx = cmd_word;
                  nxt_h.sin = cmd_word[dac_link_pkg::RD_BIT];
                  nxt_h.cnt = '0;
                  nxt_h.load_req = cmd_load;
                  nxt_h.tmr = dac_link_pkg::SCLK_HALF_TMR;
                  nxt_h.state = dac_link_pkg::H_LOW;
               end
            end
            dac_link_pkg::H_LOW: begin
               if (h_ff.tmr != 4'h0) begin
                  nxt_h.tmr = 4'(h_ff.tmr - 4'h1);
               end else begin
                  if (h_ff.cnt != 5'h00) begin
                     nxt_h.rx = {h_ff.rx[dac_link_pkg::WORD_BITS-2:0], h_ff.filt};
                  end
                  if (h_ff.cnt == dac_link_pkg::WORD_COUNT) begin
                     nxt_h.frame_n = 1'b1;
                     nxt_h.rsp_word = {h_ff.rx[dac_link_pkg::WORD_BITS-2:0], h_ff.filt};
                     nxt_h.rsp_valid = 1'b1;
                     if (h_ff.load_req && !auto_load) begin
                        nxt_h.load_n = 1'b0;
                        nxt_h.tmr = dac_link_pkg::LOAD_PULSE_TMR;
                        nxt_h.state = dac_link_pkg::H_LOAD;
                     end else begin
                        nxt_h.tmr = dac_link_pkg::GAP_TMR;
                        nxt_h.state = dac_link_pkg::H_GAP;
                     end
                  end else begin
                     nxt_h.sclk = 1'b1;
                     if (h_ff.cnt != 5'h00) begin
                        nxt_h.tx = {h_ff.tx[dac_link_pkg::WORD_BITS-2:0], 1'b0};
                        nxt_h.sin = h_ff.tx[dac_link_pkg::WORD_BITS-2];
                     end
                     nxt_h.tmr = dac_link_pkg::SCLK_HALF_TMR;
                     nxt_h.state = dac_link_pkg::H_HIGH;
                  end
               end
            end
            dac_link_pkg::H_HIGH: begin
               if (h_ff.tmr != 4'h0) begin
                  nxt_h.tmr = 4'(h_ff.tmr - 4'h1);
               end else begin
                  nxt_h.sclk = 1'b0;
                  nxt_h.cnt = 5'(h_ff.cnt + 5'h01);
                  nxt_h.tmr = dac_link_pkg::SCLK_HALF_TMR;
                  nxt_h.state = dac_link_pkg::H_LOW;
               end
            end
            dac_link_pkg::H_LOAD: begin
               nxt_h.load_n = 1'b0;
               if (h_ff.tmr != 4'h0) begin
                  nxt_h.tmr = 4'(h_ff.tmr - 4'h1);
               end else begin
                  nxt_h.load_n = 1'b1;
                  nxt_h.tmr = dac_link_pkg::GAP_TMR;
                  nxt_h.state = dac_link_pkg::H_GAP;
               end
            end
            dac_link_pkg::H_GAP: begin
               if (h_ff.tmr != 4'h0) begin
                  nxt_h.tmr = 4'(h_ff.tmr - 4'h1);
               end else begin
                  nxt_h.state = dac_link_pkg::H_IDLE;
               end
            end
            default: begin
               nxt_h.state = dac_link_pkg::H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         h_ff <= '{state: dac_link_pkg::H_IDLE, tmr: 4'h0, cnt: 5'h00, tx: '0, rx: '0,
                   sclk: 1'b0, frame_n: 1'b1, sin: 1'b0, load_n: 1'b1, clear_n: 1'b1,
                   load_req: 1'b0, s1: 1'b0, s2: 1'b0, s3: 1'b0, filt: 1'b0,
                   rsp_valid: 1'b0, rsp_word: '0};
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign cmd_ready = ce && (h_ff.state == dac_link_pkg::H_IDLE);
   assign rsp_valid = h_ff.rsp_valid;
   assign rsp_word = h_ff.rsp_word;
   assign link.link_clk = h_ff.sclk;
   assign link.serial_in = h_ff.sin;
   assign link.transmit_frame_sync_n = h_ff.frame_n;
   assign link.load_strobe_n = h_ff.load_n;
   assign link.clear_outputs_n = h_ff.clear_n;

endmodule

`default_nettype wire

// [dac_link_asserts.sv]
/*
   Wire-level checks on the link between host and DAC serial input.
   Assumes the system clock and reset of the host, and the pins of dac_link_if.
*/
`default_nettype none

module dac_link_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic serial_in,
   input wire logic transmit_frame_sync_n,
   input wire logic load_strobe_n,
   input wire logic clear_outputs_n,
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);

   logic clk_d_ff;
   logic [4:0] falls_ff;

   // Counts falling link clock edges inside a frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clk_d_ff <= 1'b0;
         falls_ff <= 5'h0;
      end else begin
         clk_d_ff <= link_clk;
         if (transmit_frame_sync_n) begin
            falls_ff <= 5'h0;
         end else if (clk_d_ff && !link_clk) begin
            falls_ff <= falls_ff + 5'h1;
         end
      end
   end

   sequence s_low_then_rise;
      !link_clk [*6] ##1 link_clk;
   endsequence
   sequence s_high_then_fall;
      link_clk [*6] ##1 !link_clk;
   endsequence

   property p_clk_idle;
      transmit_frame_sync_n |-> !link_clk;
   endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("link clock runs outside frame");
   property p_frame_start;
      $fell(transmit_frame_sync_n) |-> s_low_then_rise;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("bad frame start");
   property p_half_period;
      $rose(link_clk) |-> s_high_then_fall;
   endproperty
   a_half_period: assert property (p_half_period) else $error("bad clock high phase");
   property p_data_stable;
      $fell(link_clk) |-> $stable(serial_in);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved at fall");
   property p_data_on_rise;
      $changed(serial_in) && !transmit_frame_sync_n && $past(!transmit_frame_sync_n)
         |-> $rose(link_clk);
   endproperty
   a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off rise");
   property p_word_bits;
      $rose(transmit_frame_sync_n) |-> falls_ff == dac_link_pkg::WORD_COUNT;
   endproperty
   a_word_bits: assert property (p_word_bits) else $error("frame not 24 bits");
   property p_frame_gap;
      $rose(transmit_frame_sync_n) |-> transmit_frame_sync_n [*8];
   endproperty
   a_frame_gap: assert property (p_frame_gap) else $error("frame gap too short");
   property p_out_on_fall;
      $changed(serial_out) |-> $fell(link_clk);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("readback moved off fall");
   property p_load_after_frame;
      $fell(load_strobe_n) |-> transmit_frame_sync_n && !link_clk;
   endproperty
   a_load_after_frame: assert property (p_load_after_frame) else $error("load inside frame");

   c_clear: cover property (!clear_outputs_n);
endmodule

`default_nettype wire

// [testbench.sv]
/*
   Self-checking bench: host and DAC serial input joined by dac_link_if.
   Assumes the timing constants and word layout of dac_link_pkg.
*/
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid, cmd_load, auto_load, clear_req, cmd_ready, rsp_valid, dac_update;
   logic [23:0] cmd_word, rsp_word;
   logic [dac_link_pkg::CHANNELS-1:0][dac_link_pkg::DATA_BITS-1:0] dac_value;
   logic [13:0] vals [4] = '{14'h0123, 14'h3fff, 14'h2a55, 14'h0001};
   int bad_count = 0;
   int comparisons = 0;
   int ups;

   dac_link_if link();
   dac_frame_host dac_frame_host_i (.clock(clock), .rst(rst), .ce(1'b1), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word), .cmd_load(cmd_load),
      .auto_load(auto_load), .clear_req(clear_req), .rsp_valid(rsp_valid), .rsp_word(rsp_word));
   dac_frame_device dac_frame_device_i (.clock(clock), .rst(rst), .ce(1'b1), .link(link),
      .dac_value(dac_value), .dac_update(dac_update));
   dac_link_asserts dac_link_asserts_i (.clock(clock), .rst(rst), .link_clk(link.link_clk),
      .serial_in(link.serial_in), .transmit_frame_sync_n(link.transmit_frame_sync_n),
      .load_strobe_n(link.load_strobe_n), .clear_outputs_n(link.clear_outputs_n),
      .serial_out(link.serial_out));

   always #50 clock = ~clock;

   function automatic logic [23:0] word(input logic rd, input logic [1:0] ch,
                                        input logic [13:0] d);
      word = {rd, 5'h00, ch, 2'h0, d};
   endfunction

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Issues one command and waits for its answer, checking the fixed latency
   task automatic send(input logic [23:0] w, input logic ld);
      int n;
      n = 0;
      @(negedge clock);
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      cmd_word = w;
      cmd_load = ld;
      cmd_valid = 1'b1;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         cmd_valid = 1'b0;
      end while (rsp_valid !== 1'b1 && n < 400);
      check(24'(n), 24'h000127);
   endtask

   task automatic count_updates();
      ups = 0;
      repeat (30) begin
         @(negedge clock);
         if (dac_update === 1'b1) ups++;
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      cmd_valid = 1'b0;
      cmd_load = 1'b0;
      auto_load = 1'b1;
      clear_req = 1'b0;
      cmd_word = 24'h000000;
      repeat (3) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      for (int ch = 0; ch < 4; ch++) begin
         send(word(1'b0, 2'(ch), vals[ch]), 1'b0);
         count_updates();
         check(24'(ups), 24'h000001);
         check(24'(dac_value[ch]), 24'(vals[ch]));
      end
      $display("Test auto update done");
      send(word(1'b1, 2'h2, 14'h0000), 1'b0);
      count_updates();
      check(24'(ups), 24'h000000);
      send(word(1'b1, 2'h0, 14'h0000), 1'b0);
      check(rsp_word, {6'h00, 2'h2, 2'h0, vals[2]});
      count_updates();
      $display("Test readback done");
      auto_load = 1'b0;
      send(word(1'b0, 2'h1, 14'h1555), 1'b0);
      count_updates();
      check(24'(ups), 24'h000000);
      check(24'(dac_value[1]), 24'(vals[1]));
      send(word(1'b0, 2'h3, 14'h0aaa), 1'b1);
      count_updates();
      check(24'(ups), 24'h000001);
      check(24'(dac_value[1]), 24'h001555);
      check(24'(dac_value[3]), 24'h000aaa);
      $display("Test load strobe done");
      clear_req = 1'b1;
      repeat (10) @(negedge clock);
      check(24'(dac_value[3]), 24'h000000);
      clear_req = 1'b0;
      $display("Test clear done");
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      $display("[ERR] %0t watchdog got %h exp %h", $time, 24'h0, 24'h1);
      finish_test();
   end
endmodule

`default_nettype wire
